// ===== rtl/sbp_pkg.sv
package sbp_pkg;

    localparam logic [31:0] ADR_DATA_LINES  = 32'h1008_4600;
    localparam logic [31:0] ADR_CTL_LINES   = 32'h1008_4604;
    localparam logic [31:0] ADR_XCVR_CTL    = 32'h1008_4608;
    localparam logic [31:0] ADR_TX_LIST_PTR = 32'h1008_4640;
    localparam logic [31:0] ADR_MODE_CTL    = 32'h1008_4654;
    localparam logic [31:0] ADR_CLK_PULSE   = 32'h1008_4658;
    localparam logic [31:0] ADR_PORT_CTL    = 32'h1008_4680;

    localparam int MODE_SINGLE_STEP = 0;
    localparam int MODE_EXT_LOOP    = 1;
    localparam int MODE_PORT_DRIVE  = 2;
    localparam int MODE_INT_TEST    = 3;
    localparam int XCVR_DATA_DRIVE  = 0;
    localparam int PCTL_PARITY_EN   = 1;
    localparam int PCTL_XFER_EN     = 15;
    localparam int PCTL_PARITY_ERR  = 16;

    localparam logic [3:0]  MODE_RST  = 4'h0;
    localparam logic [15:1] PTR_RST   = 15'h0000;
    localparam logic [3:0]  XCVR_RST  = 4'h0;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [15:1] ptr;
        logic [3:0]  mode;
        logic [8:0]  dr0;
        logic [8:0]  dr1;
        logic [3:0]  dr2;
        logic        xfer_en;
        logic        par_en;
        logic        perr;
        logic [8:0]  d_s1;
        logic [8:0]  d_s2;
        logic [8:0]  c_s1;
        logic [8:0]  c_s2;
        logic [8:0]  bus_d;
        logic        bus_oe_n;
        logic [8:0]  ctl_d;
        logic        ctl_oe_n;
        logic [3:0]  xcvr;
        logic [8:0]  loop_d;
        logic [8:0]  loop_c;
        logic [3:0]  loop_x;
        logic        step;
    } sbp_state_t;

    function automatic logic [31:0] sbp_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : sbp_merge

    function automatic logic sbp_odd_ok(input logic [8:0] b);
        return ^b;
    endfunction : sbp_odd_ok

endpackage : sbp_pkg

// ===== rtl/sbp_diag_regs.sv
`timescale 1ns/1ps
module sbp_diag_regs
    import sbp_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        IO_RST_I,
    input  wire logic [31:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic             ACK_O,
    input  wire logic [8:0]  BUS_DATA_I,
    output logic      [8:0]  BUS_DATA_O,
    output logic             BUS_DATA_OE_N_O,
    input  wire logic [8:0]  BUS_CTL_I,
    output logic      [8:0]  BUS_CTL_O,
    output logic             BUS_CTL_OE_N_O,
    output logic      [3:0]  XCVR_O,
    input  wire logic [8:0]  CORE_DATA_I,
    input  wire logic        CORE_DATA_OE_I,
    input  wire logic [8:0]  CORE_CTL_I,
    input  wire logic        CORE_CTL_OE_I,
    input  wire logic [3:0]  CORE_XCVR_I,
    input  wire logic        CORE_STB_I,
    input  wire logic        TXN_DONE_I,
    input  wire logic [15:0] THREAD_WORD_I,
    output logic      [8:0]  LOOP_DATA_O,
    output logic      [8:0]  LOOP_CTL_O,
    output logic      [3:0]  LOOP_XCVR_O,
    output logic             STEP_O,
    output logic      [17:0] FETCH_ADDR_O,
    output logic             FETCH_VALID_O,
    output logic             PARITY_ERR_O
);

    sbp_state_t  s;
    sbp_state_t  next_s;
    logic        req;
    logic        wr;
    logic        clk_wr;
    logic        ptr_open;
    logic [31:0] rd;
    logic [31:0] wv;

    assign req = CYC_I & STB_I;
    // Write lands on the edge where the master sees ack
    assign wr = req & WE_I & s.ack;
    assign clk_wr = wr & (ADR_I == ADR_CLK_PULSE);
    assign ptr_open = (s.ptr == PTR_RST) | ~s.xfer_en;

    // Read view; data register shows the bus unless looped internally
    always_comb
    begin
        rd = 32'h0000_0000;
        case (ADR_I)
            ADR_DATA_LINES:
            begin
                rd[8:0] = s.mode[MODE_INT_TEST] ? s.dr0 : s.d_s2;
            end
            ADR_CTL_LINES:
            begin
                rd[8:0] = s.mode[MODE_INT_TEST] ? s.dr1 : s.c_s2;
            end
            ADR_XCVR_CTL:
            begin
                rd[3:0] = s.dr2;
            end
            ADR_TX_LIST_PTR:
            begin
                rd[15:0] = {s.ptr, 1'b0};
            end
            ADR_MODE_CTL:
            begin
                rd[3:0] = s.mode;
            end
            ADR_PORT_CTL:
            begin
                rd[PCTL_PARITY_EN] = s.par_en;
                rd[PCTL_XFER_EN] = s.xfer_en;
                rd[PCTL_PARITY_ERR] = s.perr;
            end
            default:
            begin
                rd = 32'h0000_0000;
            end
        endcase
    end

    always_comb
    begin
        next_s = s;
        wv = sbp_merge(rd, DAT_I, SEL_I);
        next_s.ack = req & ~s.ack;
        next_s.dat = (req & ~s.ack & ~WE_I) ? rd : 32'h0000_0000;
        next_s.d_s1 = BUS_DATA_I;
        next_s.d_s2 = s.d_s1;
        next_s.c_s1 = BUS_CTL_I;
        next_s.c_s2 = s.c_s1;
        if (wr)
        begin
            case (ADR_I)
                ADR_DATA_LINES:
                begin
                    next_s.dr0 = wv[8:0];
                end
                ADR_CTL_LINES:
                begin
                    next_s.dr1 = wv[8:0];
                end
                ADR_XCVR_CTL:
                begin
                    next_s.dr2 = wv[3:0];
                end
                ADR_TX_LIST_PTR:
                begin
                    if (ptr_open)
                    begin
                        next_s.ptr = wv[15:1];
                    end
                end
                ADR_MODE_CTL:
                begin
                    next_s.mode = wv[3:0];
                end
                ADR_PORT_CTL:
                begin
                    next_s.par_en = wv[PCTL_PARITY_EN];
                    next_s.xfer_en = wv[PCTL_XFER_EN];
                    // Clear only from the lane that carries the flag
                    if (SEL_I[PCTL_PARITY_ERR / 8] & DAT_I[PCTL_PARITY_ERR])
                    begin
                        next_s.perr = 1'b0;
                    end
                end
                default:
                begin
                    next_s.ack = s.ack & 1'b0;
                end
            endcase
        end
        // Completion reload beats a concurrent software write
        if (TXN_DONE_I)
        begin
            next_s.ptr = THREAD_WORD_I[15:1];
        end
        // Error set beats the software clear
        if (s.par_en & CORE_STB_I & ~sbp_odd_ok(s.loop_d))
        begin
            next_s.perr = 1'b1;
        end
        next_s.bus_d = s.mode[MODE_EXT_LOOP] ? s.dr0 : CORE_DATA_I;
        next_s.bus_oe_n = ~(s.mode[MODE_PORT_DRIVE] &
            (s.mode[MODE_EXT_LOOP] ? s.dr2[XCVR_DATA_DRIVE]
                                   : CORE_DATA_OE_I));
        next_s.ctl_d = s.mode[MODE_EXT_LOOP] ? s.dr1 : CORE_CTL_I;
        next_s.ctl_oe_n = ~(s.mode[MODE_PORT_DRIVE] &
            (s.mode[MODE_EXT_LOOP] | CORE_CTL_OE_I));
        next_s.xcvr = s.mode[MODE_EXT_LOOP] ? s.dr2 : CORE_XCVR_I;
        next_s.loop_d = s.mode[MODE_INT_TEST] ? s.dr0 : s.d_s2;
        next_s.loop_c = s.mode[MODE_INT_TEST] ? s.dr1 : s.c_s2;
        next_s.loop_x = s.mode[MODE_INT_TEST] ? s.dr2 : s.xcvr;
        // Free running unless single-stepped
        next_s.step = s.mode[MODE_SINGLE_STEP] ? clk_wr : 1'b1;
        if (IO_RST_I)
        begin
            next_s.ptr = PTR_RST;
            next_s.mode = MODE_RST;
            next_s.dr2 = XCVR_RST;
            next_s.xfer_en = 1'b0;
            next_s.par_en = 1'b0;
            next_s.perr = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            s <= '0;
            s.bus_oe_n <= 1'b1;
            s.ctl_oe_n <= 1'b1;
            s.step <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign ACK_O = s.ack;
    assign DAT_O = s.dat;
    assign BUS_DATA_O = s.bus_d;
    assign BUS_DATA_OE_N_O = s.bus_oe_n;
    assign BUS_CTL_O = s.ctl_d;
    assign BUS_CTL_OE_N_O = s.ctl_oe_n;
    assign XCVR_O = s.xcvr;
    assign LOOP_DATA_O = s.loop_d;
    assign LOOP_CTL_O = s.loop_c;
    assign LOOP_XCVR_O = s.loop_x;
    assign STEP_O = s.step;
    assign FETCH_ADDR_O = {s.ptr, 3'b000};
    assign FETCH_VALID_O = (s.ptr != PTR_RST);
    assign PARITY_ERR_O = s.perr;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    property p_ptr_locked;
        wr && ADR_I == ADR_TX_LIST_PTR && !ptr_open
            && !TXN_DONE_I && !IO_RST_I
        |=> $stable(s.ptr);
    endproperty
    a_ptr_locked: assert property (p_ptr_locked)
        else $error("locked pointer was overwritten");

    property p_ptr_write;
        wr && ADR_I == ADR_TX_LIST_PTR && ptr_open && SEL_I == 4'hf
            && !TXN_DONE_I && !IO_RST_I
        |=> s.ptr == $past(DAT_I[15:1]);
    endproperty
    a_ptr_write: assert property (p_ptr_write)
        else $error("open pointer write not taken");

    property p_reload;
        TXN_DONE_I && !IO_RST_I
        |=> FETCH_ADDR_O[17:3] == $past(THREAD_WORD_I[15:1]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("pointer not reloaded from thread word");

    property p_end_list;
        FETCH_ADDR_O == 18'h0_0000 |-> !FETCH_VALID_O;
    endproperty
    a_end_list: assert property (p_end_list)
        else $error("fetch requested at list end");

    property p_io_reset;
        IO_RST_I |=> s.mode == MODE_RST && !FETCH_VALID_O
            ##1 BUS_DATA_OE_N_O && BUS_CTL_OE_N_O;
    endproperty
    a_io_reset: assert property (p_io_reset)
        else $error("bus reset left state or drivers on");

    property p_no_drive;
        !s.mode[MODE_PORT_DRIVE] |=> BUS_DATA_OE_N_O && BUS_CTL_OE_N_O;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("bus driven with port disabled");

    property p_int_loop;
        s.mode[MODE_INT_TEST] |=> LOOP_DATA_O == $past(s.dr0)
            && LOOP_CTL_O == $past(s.dr1);
    endproperty
    a_int_loop: assert property (p_int_loop)
        else $error("internal loopback value wrong");

    property p_ext_loop;
        s.mode[MODE_EXT_LOOP] |=> BUS_DATA_O == $past(s.dr0)
            && XCVR_O == $past(s.dr2);
    endproperty
    a_ext_loop: assert property (p_ext_loop)
        else $error("external loopback value wrong");

    property p_step_pulse;
        s.mode[MODE_SINGLE_STEP] && clk_wr && !IO_RST_I
        |=> STEP_O ##1 (!STEP_O || $past(clk_wr));
    endproperty
    a_step_pulse: assert property (p_step_pulse)
        else $error("clock pulse write did not step once");

    property p_free_run;
        !s.mode[MODE_SINGLE_STEP] |=> STEP_O;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("step gated outside single-step mode");

    property p_parity;
        s.par_en && CORE_STB_I && !sbp_odd_ok(s.loop_d) && !IO_RST_I
        |=> PARITY_ERR_O [*2];
    endproperty
    a_parity: assert property (p_parity)
        else $error("even parity not flagged");

    property p_ack_once;
        ACK_O |=> !ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held past one cycle");

    property p_ptr_read;
        ACK_O && $past(req) && !$past(WE_I)
            && $past(ADR_I) == ADR_TX_LIST_PTR
        |-> DAT_O[0] == 1'b0 && DAT_O[31:16] == 16'h0000;
    endproperty
    a_ptr_read: assert property (p_ptr_read)
        else $error("pointer read shows bit 0 or upper half");

    property p_mode_write;
        wr && ADR_I == ADR_MODE_CTL && SEL_I[0] && !IO_RST_I
        |=> s.mode == $past(DAT_I[3:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write not taken from low bits");

    property p_io_ptr;
        IO_RST_I |=> s.ptr == PTR_RST && !s.xfer_en && !s.par_en;
    endproperty
    a_io_ptr: assert property (p_io_ptr)
        else $error("bus reset left pointer or enables set");

    property p_pin_view;
        ACK_O && $past(req) && !$past(WE_I)
            && $past(ADR_I) == ADR_DATA_LINES
            && !$past(s.mode[MODE_INT_TEST])
        |-> DAT_O[8:0] == $past(s.d_s2);
    endproperty
    a_pin_view: assert property (p_pin_view)
        else $error("data register read does not show the bus");

    property p_ctl_ext;
        s.mode[MODE_EXT_LOOP] |=> BUS_CTL_O == $past(s.dr1);
    endproperty
    a_ctl_ext: assert property (p_ctl_ext)
        else $error("control lines not driven from register");

    property p_xcvr_int;
        s.mode[MODE_INT_TEST] |=> LOOP_XCVR_O == $past(s.dr2);
    endproperty
    a_xcvr_int: assert property (p_xcvr_int)
        else $error("transceiver loop value wrong");

    property p_parity_off;
        !s.par_en && !PARITY_ERR_O |=> !PARITY_ERR_O;
    endproperty
    a_parity_off: assert property (p_parity_off)
        else $error("parity flagged with checking off");

    property p_port_drive;
        s.mode[MODE_PORT_DRIVE] && s.mode[MODE_EXT_LOOP]
        |=> !BUS_CTL_OE_N_O;
    endproperty
    a_port_drive: assert property (p_port_drive)
        else $error("control drivers off with port enabled");

endmodule : sbp_diag_regs

// ===== tb/sbp_bus_node.sv
`timescale 1ns/1ps
module sbp_bus_node (
    input  wire logic       clk_i,
    input  wire logic [8:0] dut_dat_i,
    input  wire logic       dut_dat_oe_n_i,
    input  wire logic [8:0] dut_ctl_i,
    input  wire logic       dut_ctl_oe_n_i,
    input  wire logic       node_drv_i,
    input  wire logic [8:0] node_dat_i,
    output logic      [8:0] dat_o,
    output logic      [8:0] ctl_o
);
    logic [8:0] idle_d = 9'h000;
    logic [8:0] idle_c = 9'h000;

    // Undriven lines keep flipping so stale values never pass
    always @(posedge clk_i)
    begin
        idle_d <= ~dat_o;
        idle_c <= ~ctl_o;
    end

    assign dat_o = !dut_dat_oe_n_i ? dut_dat_i
                 : node_drv_i ? node_dat_i : idle_d;
    assign ctl_o = !dut_ctl_oe_n_i ? dut_ctl_i : idle_c;
endmodule : sbp_bus_node

// ===== tb/storage_bus_port_diag_regs_tb_top.sv
`timescale 1ns/1ps
module storage_bus_port_diag_regs_tb_top import sbp_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        io_rst = 1'b0;
    logic [31:0] adr = '0, wdat = '0, rdat, dato, v;
    logic        we = 0, cyc = 0, stb = 0, cstb = 0, done = 0;
    logic [3:0]  sel = 4'hF, bsel = 4'hF;
    logic [15:0] thread = '0;
    logic [23:0] core = '0;
    logic        ndrv = 0;
    logic [8:0]  nval = '0, b, bdo, bco, bdi, bci, ld, lc;
    logic        ack, doe, coe, step, fv, perr;
    logic [3:0]  xo, lx;
    logic [17:0] fa;
    int          n_mismatch = 0, cmp_count = 0, steps = 0, s;

    always #20 clk = ~clk;
    always @(posedge clk) if (step === 1'b1) steps++;

    sbp_diag_regs i_dut (.CLK_I(clk), .SYS_RST_I(rst), .IO_RST_I(io_rst),
        .ADR_I(adr), .DAT_I(wdat), .DAT_O(dato), .WE_I(we), .SEL_I(sel),
        .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .BUS_DATA_I(bdi),
        .BUS_DATA_O(bdo), .BUS_DATA_OE_N_O(doe), .BUS_CTL_I(bci),
        .BUS_CTL_O(bco), .BUS_CTL_OE_N_O(coe), .XCVR_O(xo),
        .CORE_DATA_I(core[8:0]), .CORE_DATA_OE_I(core[9]),
        .CORE_CTL_I(core[18:10]), .CORE_CTL_OE_I(core[19]),
        .CORE_XCVR_I(core[23:20]), .CORE_STB_I(cstb), .TXN_DONE_I(done),
        .THREAD_WORD_I(thread), .LOOP_DATA_O(ld), .LOOP_CTL_O(lc),
        .LOOP_XCVR_O(lx), .STEP_O(step), .FETCH_ADDR_O(fa),
        .FETCH_VALID_O(fv), .PARITY_ERR_O(perr));

    sbp_bus_node i_node (.clk_i(clk), .dut_dat_i(bdo), .dut_dat_oe_n_i(doe),
        .dut_ctl_i(bco), .dut_ctl_oe_n_i(coe), .node_drv_i(ndrv),
        .node_dat_i(nval), .dat_o(bdi), .ctl_o(bci));

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask : cy

    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= bsel;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        chk("ack_wait", 2, n);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rc(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rc

    initial
    begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        v = $urandom(32'h6a6f2585);
        core <= $urandom;
        cy(2);
        rst <= 1'b0;
        @(posedge clk);
        rc("mode_rst", ADR_MODE_CTL, 0);
        rc("ptr_rst", ADR_TX_LIST_PTR, 0);
        chk("oe_n_rst", 3, {doe, coe});
        for (int i = 0; i < 5; i++)
        begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : $urandom;
            wr(ADR_TX_LIST_PTR, v);
            rc("ptr", ADR_TX_LIST_PTR, v & 32'h0000_FFFE);
            chk("fetch_addr", {v[15:1], 3'h0}, fa);
            chk("fetch_valid", |v[15:1], fv);
        end
        // Transfer enable set: only an empty pointer takes a write
        wr(ADR_TX_LIST_PTR, 0);
        wr(ADR_PORT_CTL, 32'h0000_8000);
        v = $urandom | 32'h0000_0010;
        wr(ADR_TX_LIST_PTR, v);
        rc("ptr_empty_wr", ADR_TX_LIST_PTR, v & 32'h0000_FFFE);
        wr(ADR_TX_LIST_PTR, v ^ 32'h0000_0FF0);
        rc("ptr_locked", ADR_TX_LIST_PTR, v & 32'h0000_FFFE);
        v = $urandom;
        thread <= v[15:0];
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        rc("ptr_reload", ADR_TX_LIST_PTR, v & 32'h0000_FFFE);
        wr(ADR_PORT_CTL, 0);
        wr(ADR_TX_LIST_PTR, 32'h0000_0008);
        rc("ptr_unlocked", ADR_TX_LIST_PTR, 32'h0000_0008);
        bsel = 4'h1;
        wr(ADR_TX_LIST_PTR, 32'h0000_FF30);
        bsel = 4'hF;
        rc("ptr_lane", ADR_TX_LIST_PTR, 32'h0000_0030);
        wr(ADR_MODE_CTL, 32'hFFFF_FFF0);
        rc("mode_hi", ADR_MODE_CTL, 0);
        rc("unmapped", 32'h1008_4610, 0);
        v = $urandom;
        ndrv <= 1'b1;
        nval <= v[8:0];
        cy(4);
        rc("pins", ADR_DATA_LINES, v[8:0]);
        ndrv <= 1'b0;
        wr(ADR_XCVR_CTL, 1);
        wr(ADR_MODE_CTL, 32'h6);
        wr(ADR_DATA_LINES, v);
        wr(ADR_CTL_LINES, v >> 9);
        cy(2);
        chk("bus_data", v[8:0], bdo);
        chk("bus_ctl", v[17:9], bco);
        chk("xcvr", 1, xo);
        chk("oe_n_on", 0, {doe, coe});
        rc("loop_pins", ADR_DATA_LINES, v[8:0]);
        wr(ADR_MODE_CTL, 32'h2);
        cy(2);
        chk("oe_n_off", 3, {doe, coe});
        wr(ADR_MODE_CTL, 32'h8);
        for (int i = 0; i < 3; i++)
        begin
            v = $urandom;
            b = {(i != 0) ? ^v[7:0] : ~^v[7:0], v[7:0]};
            wr(ADR_PORT_CTL, (i == 2) ? 32'h0001_0000 : 32'h0001_0002);
            wr(ADR_DATA_LINES, b);
            wr(ADR_CTL_LINES, v >> 9);
            cy(2);
            chk("loop_data", b, ld);
            chk("loop_ctl", v[17:9], lc);
            chk("loop_xcvr", 1, lx);
            cstb <= 1'b1;
            @(posedge clk);
            cstb <= 1'b0;
            cy(2);
            chk("parity_err", i == 1, perr);
        end
        wr(ADR_MODE_CTL, 0);
        wr(ADR_CLK_PULSE, 0);
        cy(2);
        chk("step_free", 1, step);
        wr(ADR_MODE_CTL, 1);
        cy(2);
        s = steps;
        wr(ADR_CLK_PULSE, 0);
        cy(3);
        chk("step_pulses", 1, steps - s);
        wr(ADR_TX_LIST_PTR, 32'h0000_0010);
        wr(ADR_MODE_CTL, 32'h6);
        io_rst <= 1'b1;
        @(posedge clk);
        io_rst <= 1'b0;
        cy(3);
        rc("io_mode", ADR_MODE_CTL, 0);
        rc("io_ptr", ADR_TX_LIST_PTR, 0);
        chk("io_oe_n", 3, {doe, coe});
        wr(ADR_MODE_CTL, 32'h4);
        cy(2);
        chk("core_data", core[8:0], bdo);
        chk("core_oe_n", {~core[9], ~core[19]}, {doe, coe});
        chk("core_ctl", core[18:10], bco);
        chk("core_xcvr", core[23:20], xo);
        chk("loop_xcvr_pins", core[23:20], lx);
        conclude();
    end
endmodule : storage_bus_port_diag_regs_tb_top
